/* File: verilog/dsg_map.svh */
// Register map constants for the deep-sleep clock gating block
`ifndef DSG_MAP_SVH
`define DSG_MAP_SVH
`define DSG_BASE_ADDR 32'h400fe000
`define DSG_DS_OFF 12'h128
`define DSG_RUN_OFF 12'h108
`define DSG_SLP_OFF 12'h118
`define DSG_RCC_OFF 12'h060
`define DSG_ACG_BIT 27
`define DSG_PHY_BIT 30
`define DSG_MAC_BIT 28
`define DSG_PORT_LO 0
`define DSG_PORT_HI 6
`define DSG_WR_MASK 32'h5000007f
`define DSG_RESET_VAL 32'h00000000
`define DSG_RCC_MASK 32'h08000000
`endif

/* File: verilog/dsg_pkg.sv */
// Types for the deep-sleep clock gating block
package dsg_pkg;
  typedef enum logic [2:0] {
    DSG_RUN = 3'b001,
    DSG_SLEEP = 3'b010,
    DSG_DEEP = 3'b100
  } dsg_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dsg_bus_t;

  typedef struct packed {
    logic [3:0] unit;
    logic wr;
    logic rd;
  } dsg_acc_t;
endpackage

/* File: verilog/dsg_clock_gate.sv */
// Clock gating control registers with access fault checking
`timescale 1ns/1ns
`include "dsg_map.svh"

module dsg_clock_gate (
  input wire logic clk,
  input wire logic reset,
  input wire dsg_pkg::dsg_bus_t bus,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire dsg_pkg::dsg_acc_t acc,
  output logic [31:0] rdata,
  output logic [8:0] clk_en,
  output logic bus_fault
);

  // ==========================================================
  // Storage
  logic [31:0] run_gating_reg_r;
  logic [31:0] sleep_gating_reg_r;
  logic [31:0] deep_sleep_gating_reg_r;
  logic [31:0] run_clock_config_r;
  logic [31:0] rdata_r;
  logic [8:0] clk_en_r;
  logic bus_fault_r;
  logic sleep_s1_r, sleep_s2_r, deep_s1_r, deep_s2_r;
  dsg_pkg::dsg_mode_t mode;

  function automatic logic [8:0] pick(input logic [31:0] v);
    pick = {v[`DSG_PHY_BIT], v[`DSG_MAC_BIT],
            v[`DSG_PORT_HI:`DSG_PORT_LO]};
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] v);
    wmask = v & `DSG_WR_MASK;
  endfunction

  // ==========================================================
  // Decode
  wire wr_run = bus.wr && bus.addr == `DSG_RUN_OFF;
  wire wr_slp = bus.wr && bus.addr == `DSG_SLP_OFF;
  wire wr_ds = bus.wr && bus.addr == `DSG_DS_OFF;
  wire wr_rcc = bus.wr && bus.addr == `DSG_RCC_OFF;
  wire auto_clock_gating_select = run_clock_config_r[`DSG_ACG_BIT];
  // Mode pins come from the power controller, another domain
  wire want_deep = deep_s2_r;
  wire want_sleep = sleep_s2_r && !deep_s2_r;
  // Without auto gating the run register stays in charge
  assign mode = !auto_clock_gating_select ? dsg_pkg::DSG_RUN :
                want_deep ? dsg_pkg::DSG_DEEP :
                want_sleep ? dsg_pkg::DSG_SLEEP : dsg_pkg::DSG_RUN;
  logic [31:0] active;
  always_comb begin
    unique case (mode)
      dsg_pkg::DSG_SLEEP: active = sleep_gating_reg_r;
      dsg_pkg::DSG_DEEP: active = deep_sleep_gating_reg_r;
      default: active = run_gating_reg_r;
    endcase
  end
  wire [8:0] en_nxt = pick(active);
  wire [31:0] rd_nxt =
    !bus.rd ? 32'h00000000 :
    bus.addr == `DSG_RUN_OFF ? run_gating_reg_r :
    bus.addr == `DSG_SLP_OFF ? sleep_gating_reg_r :
    bus.addr == `DSG_DS_OFF ? deep_sleep_gating_reg_r :
    bus.addr == `DSG_RCC_OFF ? run_clock_config_r : 32'h00000000;
  wire acc_ok = acc.unit < 4'h9;
  wire fault_nxt = (acc.rd || acc.wr) &&
                   (!acc_ok || !en_nxt[acc.unit]);

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      run_gating_reg_r <= `DSG_RESET_VAL;
      sleep_gating_reg_r <= `DSG_RESET_VAL;
      deep_sleep_gating_reg_r <= `DSG_RESET_VAL;
      run_clock_config_r <= 32'h00000000;
    end else begin
      // Reserved bits never store, so they read zero
      if (wr_run) run_gating_reg_r <= wmask(bus.wdata);
      if (wr_slp) sleep_gating_reg_r <= wmask(bus.wdata);
      if (wr_ds) deep_sleep_gating_reg_r <= wmask(bus.wdata);
      if (wr_rcc) run_clock_config_r <= bus.wdata & `DSG_RCC_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      deep_s1_r <= 1'b0;
      deep_s2_r <= 1'b0;
      rdata_r <= 32'h00000000;
      clk_en_r <= 9'h000;
      bus_fault_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep_req;
      sleep_s2_r <= sleep_s1_r;
      deep_s1_r <= deep_req;
      deep_s2_r <= deep_s1_r;
      rdata_r <= rd_nxt;
      clk_en_r <= en_nxt;
      bus_fault_r <= fault_nxt;
    end
  end

  assign rdata = rdata_r;
  assign clk_en = clk_en_r;
  assign bus_fault = bus_fault_r;

  // ==========================================================
  // Checks
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (deep_sleep_gating_reg_r & ~`DSG_WR_MASK) == 32'h0)
    else $error("reserved bit set");
  a_reset_clear: assert property (@(posedge clk)
    reset |=> clk_en == 9'h000 && deep_sleep_gating_reg_r == 32'h0)
    else $error("reset did not clear");
  a_ds_write: assert property (@(posedge clk) disable iff (reset)
    wr_ds |=> deep_sleep_gating_reg_r == wmask($past(bus.wdata)))
    else $error("deep sleep write lost");
  a_ds_read: assert property (@(posedge clk) disable iff (reset)
    bus.rd && bus.addr == `DSG_DS_OFF && !bus.wr
    |=> rdata == $past(deep_sleep_gating_reg_r))
    else $error("deep sleep read wrong");
  a_deep_apply: assert property (@(posedge clk) disable iff (reset)
    auto_clock_gating_select && want_deep |=> clk_en == $past(pick(deep_sleep_gating_reg_r)))
    else $error("deep gating not applied");
  a_no_acg_run: assert property (@(posedge clk) disable iff (reset)
    !auto_clock_gating_select |=> clk_en == $past(pick(run_gating_reg_r)))
    else $error("run gating not applied");
  a_mac_bit: assert property (@(posedge clk) disable iff (reset)
    mode == dsg_pkg::DSG_DEEP
    |=> clk_en[7] == $past(deep_sleep_gating_reg_r[`DSG_MAC_BIT]))
    else $error("mac gate wrong");
  a_fault_gated: assert property (@(posedge clk) disable iff (reset)
    (acc.rd || acc.wr) && acc_ok && !en_nxt[acc.unit] |=> bus_fault)
    else $error("missing bus fault");
  a_fault_clean: assert property (@(posedge clk) disable iff (reset)
    !(acc.rd || acc.wr) |=> !bus_fault)
    else $error("spurious bus fault");

  // ==========================================================
  // Further checks
  // Request for a clocked unit, then a quiet fault line
  sequence s_acc_live;
    (acc.rd || acc.wr) && acc_ok && en_nxt[acc.unit];
  endsequence
  sequence s_fault_low;
    !bus_fault;
  endsequence
  a_fault_live: assert property (@(posedge clk) disable iff (reset)
    s_acc_live |=> s_fault_low)
    else $error("fault on clocked unit");
  a_fault_range: assert property (@(posedge clk) disable iff (reset)
    (acc.rd || acc.wr) && !acc_ok |=> bus_fault)
    else $error("missing fault for bad unit");
  a_sleep_apply: assert property (@(posedge clk) disable iff (reset)
    mode == dsg_pkg::DSG_SLEEP
    |=> clk_en == $past(pick(sleep_gating_reg_r)))
    else $error("sleep gating not applied");
  a_run_apply: assert property (@(posedge clk) disable iff (reset)
    mode == dsg_pkg::DSG_RUN
    |=> clk_en == $past(pick(run_gating_reg_r)))
    else $error("run gating not applied in run mode");
  a_rsvd_run: assert property (@(posedge clk) disable iff (reset)
    (run_gating_reg_r & ~`DSG_WR_MASK) == 32'h0)
    else $error("reserved run bit set");
  a_rsvd_sleep: assert property (@(posedge clk) disable iff (reset)
    (sleep_gating_reg_r & ~`DSG_WR_MASK) == 32'h0)
    else $error("reserved sleep bit set");
  a_rcc_mask: assert property (@(posedge clk) disable iff (reset)
    (run_clock_config_r & ~`DSG_RCC_MASK) == 32'h0)
    else $error("config bit outside select stored");
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !bus.rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_reset_regs: assert property (@(posedge clk)
    reset |=> run_gating_reg_r == 32'h0 && sleep_gating_reg_r == 32'h0)
    else $error("gating register not cleared");
  a_reset_fault: assert property (@(posedge clk)
    reset |=> !bus_fault && rdata == 32'h0)
    else $error("outputs not cleared");
endmodule

/* File: tb/dsg_testbench.sv */
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ns
module testbench;
  logic clk, reset, sleep_req, deep_req, bus_fault;
  dsg_pkg::dsg_bus_t bus;
  dsg_pkg::dsg_acc_t acc;
  logic [31:0] rdata, rv;
  logic [8:0] clk_en;
  int n_fail, comparisons;
  dsg_clock_gate u_dut (.clk(clk), .reset(reset), .bus(bus),
    .sleep_req(sleep_req), .deep_req(deep_req), .acc(acc),
    .rdata(rdata), .clk_en(clk_en), .bus_fault(bus_fault));
  // ==========================
  // Helpers
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus.wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(logic [11:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    #1 rv = rdata;
  endtask
  task probe(logic [3:0] u, logic exp);
    @(posedge clk);
    acc <= '{unit: u, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    acc.rd <= 1'h0;
    #1 chk("bus_fault", {31'h0, bus_fault}, {31'h0, exp});
  endtask
  // Mode pins pass a two-stage sync, so allow four edges
  task settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ==========================
  // Scenarios
  task t_reset();
    rd(12'h128);
    chk("reset value", rv, 32'h0);
    chk("clk_en reset", {23'h0, clk_en}, 32'h0);
    $display("test reset done");
  endtask
  task t_regs();
    wr(12'h128, 32'hffffffff);
    rd(12'h128);
    chk("writable bits", rv, 32'h5000007f);
    wr(12'h12c, 32'hffffffff);
    rd(12'h12c);
    chk("unmapped", rv, 32'h0);
    $display("test regs done");
  endtask
  task t_modes();
    wr(12'h128, 32'h10000041);
    deep_req <= 1'h1;
    settle();
    chk("no auto gating", {23'h0, clk_en}, 32'h0);
    wr(12'h060, 32'h08000000);
    settle();
    chk("deep enables", {23'h0, clk_en}, 32'h0c1);
    probe(4'h0, 1'h0);
    probe(4'h1, 1'h1);
    probe(4'h8, 1'h1);
    probe(4'h7, 1'h0);
    deep_req <= 1'h0;
    sleep_req <= 1'h1;
    settle();
    chk("sleep enables", {23'h0, clk_en}, 32'h0);
    $display("test modes done");
  endtask
  task probe_wr(logic [3:0] u, logic exp);
    @(posedge clk);
    acc <= '{unit: u, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    acc.wr <= 1'h0;
    #1 chk("bus_fault wr", {31'h0, bus_fault}, {31'h0, exp});
  endtask
  task t_more();
    wr(12'h118, 32'h00000003);
    settle();
    chk("sleep set", {23'h0, clk_en}, 32'h003);
    probe_wr(4'h1, 1'h0);
    probe_wr(4'h2, 1'h1);
    probe_wr(4'h9, 1'h1);
    rd(12'h118);
    chk("sleep readback", rv, 32'h3);
    rd(12'h060);
    chk("config readback", rv, 32'h08000000);
    sleep_req <= 1'h0;
    wr(12'h108, 32'h40000000);
    settle();
    chk("run enables", {23'h0, clk_en}, 32'h100);
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    #1 chk("clk_en rst2", {23'h0, clk_en}, 32'h0);
    rd(12'h128);
    chk("deep rst2", rv, 32'h0);
    rd(12'h108);
    chk("run rst2", rv, 32'h0);
    $display("test more done");
  endtask
  // ==========================
  // Verdict
  task test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    reset = 1'h1;
    sleep_req = 1'h0;
    deep_req = 1'h0;
    bus = '0;
    acc = '0;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_regs();
    t_modes();
    t_more();
    test_done();
  end
endmodule
